//--- common/gic_evt_if.sv
// Bus events passed from the line front end to the byte engine
`timescale 1ns/10ps
interface gic_evt_if;
  logic start;
  logic stop;
  logic scl_rise;
  logic scl_fall;
  logic sda;
  logic tmo;
  modport link (output start, output stop, output scl_rise, output scl_fall,
    output sda, output tmo);
  modport core (input start, input stop, input scl_rise, input scl_fall,
    input sda, input tmo);
endinterface

//--- common/gic_pkg.sv
// Constants, types and location map of the gauge command port
package gic_pkg;
  localparam logic [6:0] GIC_DEV_ADDR = 7'h55;
  localparam logic [7:0] GIC_BYTE_RST = 8'h00;
  localparam logic [6:0] GIC_LOC_CTRL_HI = 7'h01;
  localparam logic [6:0] GIC_LOC_STAT_LO = 7'h02;
  localparam logic [6:0] GIC_LOC_STAT_HI = 7'h3D;
  localparam logic [6:0] GIC_LOC_DF_CLASS = 7'h3E;
  localparam logic [6:0] GIC_LOC_DF_OFFS = 7'h3F;
  localparam logic [6:0] GIC_LOC_DF_LO = 7'h40;
  localparam logic [6:0] GIC_LOC_DF_HI = 7'h5F;
  localparam logic [6:0] GIC_LOC_AUTH_LO = 7'h60;
  localparam logic [6:0] GIC_LOC_AUTH_HI = 7'h73;
  localparam logic [6:0] GIC_LOC_KEY_LO = 7'h74;
  localparam logic [6:0] GIC_LOC_KEY_HI = 7'h77;
  localparam logic [7:0] GIC_USER_CLASS = 8'h3A;
  localparam logic [7:0] GIC_USER_OFFS = 8'h00;
  localparam int GIC_NV_BYTES = 32;
  localparam int GIC_KEY_BYTES = 4;
  localparam int GIC_WR_BURST = 2;
  localparam int GIC_TMO_W = 20;
  localparam int GIC_LOCS = 128;

  typedef enum logic [8:0] {
    S_IDLE = 9'h001,
    S_ADDR = 9'h002,
    S_AACK = 9'h004,
    S_CMD = 9'h008,
    S_CACK = 9'h010,
    S_WDAT = 9'h020,
    S_WACK = 9'h040,
    S_RDAT = 9'h080,
    S_RACK = 9'h100
  } gic_state_t;
endpackage

//--- rtl/gic_cmd_port.sv
// Two-wire target command port with pointer-addressed location space
`timescale 1ns/10ps
module gic_cmd_port
  import gic_pkg::*;
#(
  parameter int WR_BURST = GIC_WR_BURST,
  parameter int TMO_W = GIC_TMO_W
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic [TMO_W-1:0] tmo_limit,
  input wire logic unlocked_security_state,
  input wire logic st_we,
  input wire logic [6:0] st_addr,
  input wire logic [7:0] st_data,
  output logic [15:0] ctrl_word,
  output logic ctrl_wr,
  output logic auth_go,
  input wire logic auth_we,
  input wire logic [4:0] auth_idx,
  input wire logic [7:0] auth_data,
  output logic [8*GIC_KEY_BYTES-1:0] auth_key
);
  gic_evt_if ev ();

  gic_link #(.TMO_W(TMO_W)) u_link (
    .clk(clk),
    .rstn(rstn),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .tmo_limit(tmo_limit),
    .ev(ev.link)
  );

  gic_state_t st_q, st_d;
  logic [2:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d;
  logic [6:0] ptr_q, ptr_d;
  logic rw_q, rw_d;
  logic bad_q, bad_d;
  logic got_q, got_d;
  logic low_q, low_d;
  logic mack_q, mack_d;
  logic [3:0] nwr_q, nwr_d;
  logic ctrl_wr_q, ctrl_wr_d;
  logic auth_go_q, auth_go_d;
  logic [7:0] mem_q [0:GIC_LOCS-1];
  logic [7:0] key_q [0:GIC_KEY_BYTES-1];

  logic hw_we;
  logic wr_ok;
  logic in_key, in_dfw, in_auth, df_sel;
  logic [7:0] nv_rd;
  logic [7:0] rd_byte;
  logic nv_we;
  logic mem_we;
  logic [6:0] mem_wa;
  logic [7:0] mem_wd;
  logic key_we;
  logic [6:0] auth_loc;

  // Location classes for the current pointer
  assign in_key = ptr_q >= GIC_LOC_KEY_LO && ptr_q <= GIC_LOC_KEY_HI;
  assign in_dfw = ptr_q >= GIC_LOC_DF_LO && ptr_q <= GIC_LOC_DF_HI;
  assign in_auth = ptr_q >= GIC_LOC_AUTH_LO && ptr_q <= GIC_LOC_AUTH_HI;
  // Window maps to user area only for its subclass and offset
  assign df_sel = mem_q[GIC_LOC_DF_CLASS] == GIC_USER_CLASS
    && mem_q[GIC_LOC_DF_OFFS] == GIC_USER_OFFS;

  // Control, flash selectors, window and scratch pad are host writable
  assign wr_ok = ptr_q <= GIC_LOC_CTRL_HI
    || (ptr_q >= GIC_LOC_DF_CLASS && ptr_q <= GIC_LOC_AUTH_HI)
    || (in_key && unlocked_security_state);

  // Keys never read back; a hash key must not leak
  always_comb begin
    if (in_key) begin
      rd_byte = GIC_BYTE_RST;
    end else if (in_dfw && df_sel) begin
      rd_byte = nv_rd;
    end else begin
      rd_byte = mem_q[ptr_q];
    end
  end

  gic_nvm #(.DEPTH(GIC_NV_BYTES)) u_nvm (
    .clk(clk),
    .we(nv_we),
    .addr(ptr_q[4:0]),
    .wdata(sh_q),
    .rdata(nv_rd)
  );

  // Byte engine
  always_comb begin
    st_d = st_q;
    bit_d = bit_q;
    sh_d = sh_q;
    ptr_d = ptr_q;
    rw_d = rw_q;
    bad_d = bad_q;
    got_d = got_q;
    low_d = low_q;
    mack_d = mack_q;
    nwr_d = nwr_q;
    hw_we = 1'b0;
    if (ev.tmo || ev.stop) begin
      // Timeout releases the data line so the master can recover
      st_d = S_IDLE;
      low_d = 1'b0;
      got_d = 1'b0;
      if (ev.stop) begin
        bad_d = 1'b0;
      end
    end else if (ev.start) begin
      st_d = S_ADDR;
      bit_d = 3'd0;
      got_d = 1'b0;
      low_d = 1'b0;
      nwr_d = 4'h0;
    end else begin
      unique case (st_q)
        S_IDLE: begin
          st_d = S_IDLE;
        end
        S_ADDR, S_CMD, S_WDAT: begin
          if (ev.scl_rise) begin
            sh_d = {sh_q[6:0], ev.sda};
            bit_d = bit_q + 3'd1;
            got_d = bit_q == 3'd7;
          end else if (ev.scl_fall && got_q) begin
            got_d = 1'b0;
            if (st_q == S_ADDR) begin
              // Read after a refused command, before any stop, gets no answer at all
              if (sh_q[7:1] == GIC_DEV_ADDR && !(sh_q[0] && bad_q)) begin
                rw_d = sh_q[0];
                low_d = 1'b1;
                st_d = S_AACK;
              end else begin
                st_d = S_IDLE;
              end
            end else if (st_q == S_CMD) begin
              st_d = S_CACK;
              if (sh_q[7]) begin
                bad_d = 1'b1;
                low_d = 1'b0;
              end else begin
                bad_d = 1'b0;
                ptr_d = sh_q[6:0];
                low_d = 1'b1;
              end
            end else begin
              st_d = S_WACK;
              if (nwr_q < 4'(WR_BURST) && wr_ok) begin
                hw_we = 1'b1;
                ptr_d = ptr_q + 7'd1;
                low_d = 1'b1;
              end
              if (nwr_q != 4'hF) begin
                nwr_d = nwr_q + 4'h1;
              end
            end
          end
        end
        S_AACK: begin
          if (ev.scl_fall) begin
            bit_d = 3'd0;
            if (rw_q) begin
              // Read starts wherever the pointer stands
              sh_d = rd_byte;
              low_d = !rd_byte[7];
              st_d = S_RDAT;
            end else begin
              low_d = 1'b0;
              st_d = S_CMD;
            end
          end
        end
        S_CACK, S_WACK: begin
          if (ev.scl_fall) begin
            low_d = 1'b0;
            bit_d = 3'd0;
            st_d = (st_q == S_CACK && bad_q) ? S_IDLE : S_WDAT;
          end
        end
        S_RDAT: begin
          if (ev.scl_fall) begin
            if (bit_q == 3'd7) begin
              low_d = 1'b0;
              st_d = S_RACK;
            end else begin
              bit_d = bit_q + 3'd1;
              sh_d = {sh_q[6:0], 1'b0};
              low_d = !sh_q[6];
            end
          end
        end
        S_RACK: begin
          if (ev.scl_rise) begin
            mack_d = !ev.sda;
            if (!ev.sda) begin
              ptr_d = ptr_q + 7'd1;
            end
          end else if (ev.scl_fall) begin
            bit_d = 3'd0;
            if (mack_q) begin
              // Incremental read: 0x7F wraps to 0x00
              sh_d = rd_byte;
              low_d = !rd_byte[7];
              st_d = S_RDAT;
            end else begin
              st_d = S_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Write routing; host beats the gauge core in a same-cycle clash
  assign auth_loc = GIC_LOC_AUTH_LO + {2'b00, auth_idx};
  always_comb begin
    nv_we = hw_we && in_dfw && df_sel;
    key_we = hw_we && in_key;
    mem_we = 1'b0;
    mem_wa = ptr_q;
    mem_wd = sh_q;
    ctrl_wr_d = hw_we && ptr_q == GIC_LOC_CTRL_HI;
    auth_go_d = hw_we && ptr_q == GIC_LOC_AUTH_HI;
    if (hw_we && !in_key && !(in_dfw && df_sel)) begin
      mem_we = 1'b1;
    end else if (st_we && st_addr >= GIC_LOC_STAT_LO && st_addr <= GIC_LOC_STAT_HI) begin
      mem_we = 1'b1;
      mem_wa = st_addr;
      mem_wd = st_data;
    end else if (auth_we && auth_loc <= GIC_LOC_AUTH_HI) begin
      mem_we = 1'b1;
      mem_wa = auth_loc;
      mem_wd = auth_data;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= S_IDLE;
      bit_q <= 3'd0;
      sh_q <= GIC_BYTE_RST;
      ptr_q <= 7'h00;
      rw_q <= 1'b0;
      bad_q <= 1'b0;
      got_q <= 1'b0;
      low_q <= 1'b0;
      mack_q <= 1'b0;
      nwr_q <= 4'h0;
      ctrl_wr_q <= 1'b0;
      auth_go_q <= 1'b0;
      for (int i = 0; i < GIC_LOCS; i++) begin
        mem_q[i] <= GIC_BYTE_RST;
      end
      for (int k = 0; k < GIC_KEY_BYTES; k++) begin
        key_q[k] <= GIC_BYTE_RST;
      end
    end else begin
      st_q <= st_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      ptr_q <= ptr_d;
      rw_q <= rw_d;
      bad_q <= bad_d;
      got_q <= got_d;
      low_q <= low_d;
      mack_q <= mack_d;
      nwr_q <= nwr_d;
      ctrl_wr_q <= ctrl_wr_d;
      auth_go_q <= auth_go_d;
      if (mem_we) begin
        mem_q[mem_wa] <= mem_wd;
      end
      if (key_we) begin
        key_q[ptr_q[1:0]] <= sh_q;
      end
    end
  end

  // Open drain: only ever pull low; clock never stretched
  assign sda_o = 1'b0;
  assign sda_oe = low_q;
  assign scl_o = 1'b0;
  assign scl_oe = 1'b0;
  assign ctrl_word = {mem_q[GIC_LOC_CTRL_HI], mem_q[0]};
  assign ctrl_wr = ctrl_wr_q;
  assign auth_go = auth_go_q;
  always_comb begin
    for (int k = 0; k < GIC_KEY_BYTES; k++) begin
      auth_key[8*k +: 8] = key_q[k];
    end
  end
endmodule

//--- rtl/gic_link.sv
// Line front end: edge, start, stop and low-bus timeout detection
`timescale 1ns/10ps
module gic_link
  import gic_pkg::*;
#(
  parameter int TMO_W = GIC_TMO_W
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic [TMO_W-1:0] tmo_limit,
  gic_evt_if.link ev
);
  logic scl_q, scl_d;
  logic sda_q, sda_d;
  logic [TMO_W-1:0] cnt_q, cnt_d;
  logic tmo_q, tmo_d;

  always_comb begin
    scl_d = scl_i;
    sda_d = sda_i;
    tmo_d = 1'b0;
    cnt_d = cnt_q;
    // Zero limit disables the watchdog
    if ((scl_i && sda_i) || tmo_limit == '0) begin
      cnt_d = '0;
    end else if (cnt_q != tmo_limit) begin
      cnt_d = cnt_q + 1'b1;
      tmo_d = (cnt_q + 1'b1) == tmo_limit;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      cnt_q <= '0;
      tmo_q <= 1'b0;
    end else begin
      scl_q <= scl_d;
      sda_q <= sda_d;
      cnt_q <= cnt_d;
      tmo_q <= tmo_d;
    end
  end

  // Start and stop are sda edges while scl stays high
  assign ev.start = scl_q && scl_i && sda_q && !sda_i;
  assign ev.stop = scl_q && scl_i && !sda_q && sda_i;
  assign ev.scl_rise = !scl_q && scl_i;
  assign ev.scl_fall = scl_q && !scl_i;
  assign ev.sda = sda_i;
  assign ev.tmo = tmo_q;
endmodule

//--- rtl/gic_nvm.sv
// User nonvolatile byte area behind the data-flash window
`timescale 1ns/10ps
module gic_nvm
  import gic_pkg::*;
#(
  parameter int DEPTH = GIC_NV_BYTES
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [$clog2(DEPTH)-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  // No reset: contents must survive a reset like flash does
  logic [7:0] arr_q [0:DEPTH-1];

  always_ff @(posedge clk) begin
    if (we) begin
      arr_q[addr] <= wdata;
    end
  end

  assign rdata = arr_q[addr];
endmodule

//--- tb/gic_cmd_port_sva.sv
// Port checker for the command port
`timescale 1ns/10ps
module gic_cmd_port_sva
  import gic_pkg::*;
#(
  parameter int WR_BURST = GIC_WR_BURST,
  parameter int TMO_W = GIC_TMO_W
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic [TMO_W-1:0] tmo_limit,
  input wire logic [15:0] ctrl_word,
  input wire logic ctrl_wr
);
  logic [TMO_W:0] low_q;
  logic [TMO_W:0] low_d;
  // Clock-low time only: a lower bound under any reading of bus low
  always_comb begin
    low_d = scl_i ? '0 : low_q + 1'b1;
    if (&low_q) low_d = low_q;
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) low_q <= '0;
    else low_q <= low_d;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  AST_SCL_FREE: assert property (scl_oe == 1'b0 && scl_o == 1'b0)
    else $error("device drove the clock line");
  AST_SDA_PULL: assert property (sda_o == 1'b0)
    else $error("data line driven high");
  AST_OE_ON_LOW: assert property ($changed(sda_oe) |-> !scl_i)
    else $error("data drive changed with clock high");
  AST_OE_AFTER_FALL: assert property ($rose(sda_oe) |-> !$past(scl_i))
    else $error("data drive rose without a clock fall");
  AST_OE_HOLD: assert property (scl_i && sda_oe && tmo_limit == '0 |=> sda_oe || !scl_i)
    else $error("data drive dropped while clock high");
  AST_CTRL_PULSE: assert property (ctrl_wr |=> !ctrl_wr)
    else $error("control strobe longer than one cycle");
  AST_CTRL_LOW: assert property ($changed(ctrl_word) |-> !scl_i && !$past(scl_i))
    else $error("control word changed outside clock low");
  AST_TMO: assert property (tmo_limit != '0 && low_q >= {1'b0, tmo_limit} + 3 |-> !sda_oe)
    else $error("data line held after bus timeout");
  cover property ($rose(ctrl_wr));
  cover property ($rose(sda_oe));
  cover property (tmo_limit != '0 && $fell(sda_oe));
endmodule
bind gic_cmd_port gic_cmd_port_sva #(.WR_BURST(WR_BURST), .TMO_W(TMO_W)) sva_u (.clk, .rstn,
  .scl_i, .scl_o, .scl_oe, .sda_i, .sda_o, .sda_oe, .tmo_limit, .ctrl_word, .ctrl_wr);

//--- tb/gic_cmd_port_tb.sv
// Self-checking bench for the command port
`timescale 1ns/10ps
`define CHK(nm, exp, got) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
      error_cnt++; \
      $display("mismatch %s exp %0h got %0h", nm, exp, got); \
    end \
  end
module gic_cmd_port_tb;
  import gic_pkg::*;
  typedef struct {
    logic [31:0] b;
    int n;
    logic [3:0] ack;
  } gic_row_t;
  localparam logic [7:0] ADDR_W = {GIC_DEV_ADDR, 1'b0};
  // Bytes sent left first, expected acknowledge per byte
  gic_row_t rows [4] = '{
    '{32'hAA001234, 4, 4'b1111},
    '{32'hAA027700, 3, 4'b1100},
    '{32'hAA800000, 2, 4'b1000},
    '{32'h54000000, 1, 4'b0000}};
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic scl, sda_m, sda, scl_w, scl_o, scl_oe, sda_o, sda_oe, ctrl_wr, st_we, ack, s;
  logic [GIC_TMO_W-1:0] tmo_limit;
  logic [6:0] st_addr;
  logic [7:0] st_data, rd;
  logic [15:0] ctrl_word;
  logic [31:0] auth_key;
  logic unlocked_security_state, auth_we, auth_go;
  logic [4:0] auth_idx;
  logic [7:0] auth_data;
  int error_cnt = 0;
  int n_compared = 0;
  int wr_cnt = 0;
  int go_cnt = 0;
  assign sda = sda_m & ~sda_oe;
  assign scl_w = scl & ~scl_oe;
  always #2 clk = ~clk;
  always @(posedge clk) if (ctrl_wr === 1'b1) wr_cnt++;
  always @(posedge clk) if (auth_go === 1'b1) go_cnt++;
  gic_host host_u (.clk, .sda, .scl, .sda_m);
  gic_cmd_port dut_u (.clk, .rstn, .scl_i(scl_w), .scl_o, .scl_oe, .sda_i(sda), .sda_o,
    .sda_oe, .tmo_limit, .unlocked_security_state, .st_we, .st_addr, .st_data,
    .ctrl_word, .ctrl_wr, .auth_go, .auth_we, .auth_idx, .auth_data,
    .auth_key);
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    st_we = 1'b0;
    st_addr = 7'h00;
    st_data = 8'h00;
    tmo_limit = '0;
    unlocked_security_state = 1'b0;
    auth_we = 1'b0;
    auth_idx = 5'h00;
    auth_data = 8'h00;
    host_u.hold(10);
    `CHK("rst oe", 1'b0, sda_oe)
    `CHK("rst ctrl", 16'h0000, ctrl_word)
    `CHK("rst key", 32'h00000000, auth_key)
    rstn = 1'b1;
    host_u.hold(2);
    st_we = 1'b1;
    st_addr = 7'h02;
    st_data = 8'hC5;
    host_u.hold(1);
    st_addr = 7'h03;
    st_data = 8'hD6;
    host_u.hold(1);
    st_we = 1'b0;
    foreach (rows[k]) begin
      host_u.start();
      for (int j = 0; j < rows[k].n; j++) begin
        host_u.xfer(rows[k].b[31-8*j -: 8], 1'b1, rd, ack);
        `CHK("ack", rows[k].ack[3-j], ack)
      end
      host_u.stop();
    end
    `CHK("ctrl_word", 16'h3412, ctrl_word)
    `CHK("ctrl_wr", 1, wr_cnt)
    // Pointer left at 0x02 by the refused writes
    host_u.start();
    host_u.xfer(8'hAB, 1'b1, rd, ack);
    host_u.xfer(8'hFF, 1'b0, rd, ack);
    `CHK("quick rd", 8'hC5, rd)
    host_u.xfer(8'hFF, 1'b1, rd, ack);
    `CHK("next rd", 8'hD6, rd)
    host_u.stop();
    host_u.start();
    host_u.xfer(8'hAA, 1'b1, rd, ack);
    host_u.xfer(8'h00, 1'b1, rd, ack);
    host_u.start();
    host_u.xfer(8'hAB, 1'b1, rd, ack);
    host_u.xfer(8'hFF, 1'b1, rd, ack);
    `CHK("sr rd", 8'h12, rd)
    host_u.stop();
    // Hash engine answer lands while the bus is idle
    unlocked_security_state = 1'b1;
    auth_data = 8'hE7;
    auth_we = 1'b1;
    host_u.hold(1);
    auth_we = 1'b0;
    // Last challenge byte, then first key byte while unlocked
    host_u.start();
    host_u.xfer(8'hAA, 1'b1, rd, ack);
    host_u.xfer(8'h73, 1'b1, rd, ack);
    host_u.xfer(8'hC3, 1'b1, rd, ack);
    host_u.xfer(8'h44, 1'b1, rd, ack);
    `CHK("key ack", 1'b1, ack)
    host_u.stop();
    unlocked_security_state = 1'b0;
    `CHK("auth_go", 1, go_cnt)
    `CHK("auth_key", 32'h00000044, auth_key)
    host_u.start();
    host_u.xfer(8'hAA, 1'b1, rd, ack);
    host_u.xfer(8'h60, 1'b1, rd, ack);
    host_u.start();
    host_u.xfer(8'hAB, 1'b1, rd, ack);
    host_u.xfer(8'hFF, 1'b1, rd, ack);
    `CHK("auth rd", 8'hE7, rd)
    host_u.stop();
    // Clock parked low during the address acknowledge
    tmo_limit = 20'd1500;
    host_u.start();
    for (int i = 7; i >= 0; i--) begin
      host_u.clk_bit(ADDR_W[i], s);
    end
    host_u.hold(4);
    `CHK("addr ack", 1'b1, sda_oe)
    host_u.hold(1600);
    `CHK("tmo release", 1'b0, sda_oe)
    host_u.stop();
    summarize();
  end
endmodule

//--- tb/gic_host.sv
// Two-wire bus master model for the command port
`timescale 1ns/10ps
module gic_host (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_m
);
  // 626 clk per bit keeps the clock just under the bus limit
  localparam int HALF = 313;
  localparam int Q = HALF / 2;
  // High means released; the pull-up then gives idle high
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Data changes mid-low, sampled mid-high
  task automatic clk_bit(input logic b, output logic s);
    hold(Q);
    sda_m = b;
    hold(HALF - Q);
    scl = 1'b1;
    hold(Q);
    s = sda;
    hold(HALF - Q);
    scl = 1'b0;
  endtask
  task automatic start();
    hold(Q);
    sda_m = 1'b1;
    hold(Q);
    scl = 1'b1;
    hold(Q);
    sda_m = 1'b0;
    hold(Q);
    scl = 1'b0;
  endtask
  task automatic stop();
    hold(Q);
    sda_m = 1'b0;
    hold(Q);
    scl = 1'b1;
    hold(Q);
    sda_m = 1'b1;
    hold(HALF);
  endtask
  // Byte MSB first, then ninth bit; mack low acknowledges a read byte
  task automatic xfer(input logic [7:0] b, input logic mack, output logic [7:0] r,
    output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(b[i], r[i]);
    end
    clk_bit(mack, a);
    ack = ~a;
  endtask
endmodule
